// [logic/clms_pkg.sv]
// Shared constants and types for the character LCD memory map and scan core.
package clms_pkg;

    // Clock and scan timing.
    localparam int CLK_HZ = 20_000_000;
    localparam int COM_PERIOD_NS = 100_000;
    localparam int COM_CYCLES =
        (COM_PERIOD_NS * (CLK_HZ / 1_000_000) + 999) / 1000;

    // Panel geometry.
    localparam int NUM_COM = 17;
    localparam int NUM_SEG = 80;
    localparam int PANEL_CHARS = 16;
    localparam int DOT_COLS = 5;
    localparam int DOT_ROWS = 8;
    localparam int ICON_ENTRIES = 16;
    localparam int GLYPH_ENTRIES = 64;

    // Character-code RAM layout.
    localparam int CHAR_DEPTH = 80;
    localparam logic [6:0] ONE_LINE_LEN = 7'h50;
    localparam logic [6:0] TWO_LINE_LEN = 7'h28;
    localparam logic [6:0] ONE_LINE_LAST = 7'h4F;
    localparam logic [6:0] LINE1_LAST = 7'h27;
    localparam logic [6:0] LINE2_BASE = 7'h40;
    localparam logic [6:0] LINE2_LAST = 7'h67;
    localparam logic [6:0] LINE2_SLOT_GAP = 7'h18;

    // Pattern ROM sizes chosen by the two font-size option pins.
    localparam logic [8:0] ROM_COUNT_00 = 9'h0F0;
    localparam logic [8:0] ROM_COUNT_01 = 9'h0FA;
    localparam logic [8:0] ROM_COUNT_10 = 9'h0F8;
    localparam logic [8:0] ROM_COUNT_11 = 9'h100;

    // Instruction field positions and codes.
    localparam int INS_N_BIT = 3;
    localparam int INS_SHIFT_BIT = 3;
    localparam int INS_RIGHT_BIT = 2;
    localparam int INS_INC_BIT = 1;
    localparam logic [1:0] INS_GLYPH_ADDR = 2'h1;
    localparam logic [3:0] INS_ICON_ADDR = 4'h3;
    localparam logic [3:0] INS_FUNC_SET = 4'h2;
    localparam logic [3:0] INS_SHIFT = 4'h1;
    localparam logic [5:0] INS_ENTRY = 6'h01;

    // Reset values.
    localparam logic [6:0] PTR_RST = 7'h00;
    localparam logic TWO_LINE_RST = 1'b0;
    localparam logic INC_RST = 1'b1;

    typedef enum logic [2:0] {
        TGT_CHAR = 3'b001,
        TGT_GLYPH = 3'b010,
        TGT_ICON = 3'b100
    } clms_tgt_e;

    typedef struct packed {
        logic rs;
        logic [7:0] data;
    } clms_wr_s;

endpackage

// [logic/clms_core.sv]
// Character LCD core: host write path, RAMs, display mapping and panel scan.
`timescale 1ns/100ps
`default_nettype none

// Operation
// - One-line mode maps positions 1 to 80 onto addresses 00 to 4F.
// - One-line single controller shows 16 characters, addresses 00 to 0F.
// - One-line shift moves window by one; right shift puts 4F before 00.
// - Two-line mode: line one from 00-27, line two from 40-67.
// - Unshifted 16x2 window shows 00-0F and 40-4F.
// - Two-line shift moves both lines; wraps 27 to 00 and 67 to 40.
// - Each 8-bit character code from 10 up to the ROM count yields a 5x8 pattern from ROM.
// - ROM holds 240, 250, 248 or 256 patterns per option pins.
// - Pattern RAM holds eight user 5x8 patterns written by the host.
// - Unused pattern RAM bits are kept as write-only storage.
// - Icon RAM holds 80 host-writable dots driving icon segments.
// - Refresh reads and host writes use separate timing, no flicker.
// - Host path is write only; no read path exists.
// - Panel driver has 17 common and 80 segment outputs.
// - Pattern bits shift serially into 80-bit latch, then move in parallel.
// - A 17-bit common register selects one common while segments drive.
// - Character RAM holds 80 bytes; hidden entries are general storage.
// - Pointer steps by one after each RAM write, up or down by mode.
// - Codes with bits 7..4 zero pick pattern RAM; bit 3 ignored.
module clms_core #(
    parameter int COM_CYCLES = clms_pkg::COM_CYCLES
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Host write stream from the serial front end.
    input wire logic i_wr_valid,
    input wire clms_pkg::clms_wr_s i_wr,
    output logic o_wr_ready,
    // Font-size option pins.
    input wire logic i_font_size_option_a,
    input wire logic i_font_size_option_b,
    // Panel drive.
    output logic [clms_pkg::NUM_COM-1:0] o_com,
    output logic [clms_pkg::NUM_SEG-1:0] o_seg
);

    localparam int PW = $clog2(COM_CYCLES);
    localparam logic [PW-1:0] PHASE_LAST = PW'(COM_CYCLES - 1);
    localparam logic [PW-1:0] SHIFT_END = PW'(clms_pkg::NUM_SEG);

    // Storage. The scan reads these combinationally on its own counters,
    // so host writes never wait for, or stall, the refresh.
    logic [7:0] char_ram_q [clms_pkg::CHAR_DEPTH];
    logic [7:0] glyph_ram_q [clms_pkg::GLYPH_ENTRIES];
    logic [4:0] icon_ram_q [clms_pkg::ICON_ENTRIES];

    logic [6:0] address_pointer_q;
    clms_pkg::clms_tgt_e tgt_q;
    logic two_line_q;
    logic inc_q;
    logic [6:0] shift_off_q;
    // Length of the shift window, declared here because the decode reads it.
    logic [6:0] win_len;

    // Maps a pointer value to a storage slot; bit 7 flags a valid slot.
    function automatic logic [7:0] char_slot(input logic [6:0] a,
                                             input logic two);
        logic [7:0] s;
        s = 8'h00;
        if (two) begin
            if (a <= clms_pkg::LINE1_LAST) begin
                s = {1'b1, a};
            end else if (a >= clms_pkg::LINE2_BASE &&
                         a <= clms_pkg::LINE2_LAST) begin
                s = {1'b1, a - clms_pkg::LINE2_SLOT_GAP};
            end
        end else if (a <= clms_pkg::ONE_LINE_LAST) begin
            s = {1'b1, a};
        end
        return s;
    endfunction

    // Pointer step after a data write, wrapping inside the active map.
    function automatic logic [6:0] next_ptr(input logic [6:0] p,
                                            input clms_pkg::clms_tgt_e t,
                                            input logic two,
                                            input logic up);
        logic [6:0] n;
        n = up ? p + 7'h01 : p - 7'h01;
        if (t == clms_pkg::TGT_GLYPH) begin
            n = {1'b0, n[5:0]};
        end else if (t == clms_pkg::TGT_ICON) begin
            n = {3'b000, n[3:0]};
        end else if (!two) begin
            if (up && p == clms_pkg::ONE_LINE_LAST) begin
                n = 7'h00;
            end else if (!up && p == 7'h00) begin
                n = clms_pkg::ONE_LINE_LAST;
            end
        end else if (up && p == clms_pkg::LINE1_LAST) begin
            n = clms_pkg::LINE2_BASE;
        end else if (up && p == clms_pkg::LINE2_LAST) begin
            n = 7'h00;
        end else if (!up && p == clms_pkg::LINE2_BASE) begin
            n = clms_pkg::LINE1_LAST;
        end else if (!up && p == 7'h00) begin
            n = clms_pkg::LINE2_LAST;
        end
        return n;
    endfunction

    // Stand-in ROM pattern: real fonts are mask data outside this core.
    function automatic logic [4:0] rom_dots(input logic [7:0] code,
                                            input logic [2:0] row);
        return code[4:0] ^ {code[7:6], row};
    endfunction

    // Two-entry write buffer. The drain takes one entry per cycle, so a
    // full buffer only stalls the sender until the next cycle.
    clms_pkg::clms_wr_s buf_q [2];
    logic buf_wp_q;
    logic buf_rp_q;
    logic [1:0] buf_cnt_q;
    logic push;
    logic pop;
    logic [1:0] buf_cnt_d;

    assign push = i_wr_valid && o_wr_ready;
    assign pop = buf_cnt_q != 2'h0;

    always_comb begin
        buf_cnt_d = buf_cnt_q;
        if (push && !pop) begin
            buf_cnt_d = buf_cnt_q + 2'h1;
        end else if (pop && !push) begin
            buf_cnt_d = buf_cnt_q - 2'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            buf_wp_q <= 1'b0;
            buf_rp_q <= 1'b0;
            buf_cnt_q <= 2'h0;
            o_wr_ready <= 1'b0;
        end else begin
            buf_cnt_q <= buf_cnt_d;
            o_wr_ready <= buf_cnt_d != 2'h2;
            if (push) begin
                buf_wp_q <= ~buf_wp_q;
            end
            if (pop) begin
                buf_rp_q <= ~buf_rp_q;
            end
        end
    end

    always_ff @(posedge i_clk) begin
        if (push) begin
            buf_q[buf_wp_q] <= i_wr;
        end
    end

    clms_pkg::clms_wr_s head;
    logic [7:0] wslot;
    assign head = buf_q[buf_rp_q];
    assign wslot = char_slot(address_pointer_q, two_line_q);

    // Host data writes land in the selected RAM; nothing is ever read
    // back toward the host.
    always_ff @(posedge i_clk) begin
        if (pop && head.rs) begin
            unique case (tgt_q)
                clms_pkg::TGT_CHAR: begin
                    if (wslot[7]) begin
                        char_ram_q[wslot[6:0]] <= head.data;
                    end
                end
                clms_pkg::TGT_GLYPH: begin
                    // All eight bits are kept, display uses only the low five.
                    glyph_ram_q[address_pointer_q[5:0]] <= head.data;
                end
                clms_pkg::TGT_ICON: begin
                    icon_ram_q[address_pointer_q[3:0]] <= head.data[4:0];
                end
            endcase
        end
    end

    // Instruction decode and pointer upkeep.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            address_pointer_q <= clms_pkg::PTR_RST;
            tgt_q <= clms_pkg::TGT_CHAR;
            two_line_q <= clms_pkg::TWO_LINE_RST;
            inc_q <= clms_pkg::INC_RST;
            shift_off_q <= 7'h00;
        end else if (pop && head.rs) begin
            address_pointer_q <= next_ptr(address_pointer_q, tgt_q,
                                          two_line_q, inc_q);
        end else if (pop) begin
            if (head.data[7]) begin
                address_pointer_q <= head.data[6:0];
                tgt_q <= clms_pkg::TGT_CHAR;
            end else if (head.data[7:6] == clms_pkg::INS_GLYPH_ADDR) begin
                address_pointer_q <= {1'b0, head.data[5:0]};
                tgt_q <= clms_pkg::TGT_GLYPH;
            end else if (head.data[7:4] == clms_pkg::INS_ICON_ADDR) begin
                address_pointer_q <= {3'b000, head.data[3:0]};
                tgt_q <= clms_pkg::TGT_ICON;
            end else if (head.data[7:4] == clms_pkg::INS_FUNC_SET) begin
                // A mode change restarts the window so it stays in range.
                two_line_q <= head.data[clms_pkg::INS_N_BIT];
                shift_off_q <= 7'h00;
            end else if (head.data[7:4] == clms_pkg::INS_SHIFT &&
                         head.data[clms_pkg::INS_SHIFT_BIT]) begin
                if (!head.data[clms_pkg::INS_RIGHT_BIT]) begin
                    shift_off_q <= (shift_off_q == win_len - 7'h01) ?
                                   7'h00 : shift_off_q + 7'h01;
                end else begin
                    shift_off_q <= (shift_off_q == 7'h00) ?
                                   win_len - 7'h01 : shift_off_q - 7'h01;
                end
            end else if (head.data[7:2] == clms_pkg::INS_ENTRY) begin
                inc_q <= head.data[clms_pkg::INS_INC_BIT];
            end
        end
    end

    // Option pins come from outside the clock domain.
    logic [1:0] opt_meta_q;
    logic [1:0] opt_q;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            opt_meta_q <= 2'b00;
            opt_q <= 2'b00;
        end else begin
            opt_meta_q <= {i_font_size_option_b, i_font_size_option_a};
            opt_q <= opt_meta_q;
        end
    end

    logic [8:0] rom_count;
    always_comb begin
        unique case (opt_q)
            2'b00: rom_count = clms_pkg::ROM_COUNT_00;
            2'b01: rom_count = clms_pkg::ROM_COUNT_01;
            2'b10: rom_count = clms_pkg::ROM_COUNT_10;
            2'b11: rom_count = clms_pkg::ROM_COUNT_11;
        endcase
    end

    // Scan counters: phase within one common period, character, dot column
    // and row (rows 0..7 line one, 8..15 line two, 16 icons).
    logic [PW-1:0] phase_q;
    logic [3:0] char_q;
    logic [2:0] col_q;
    logic [4:0] row_q;
    logic [clms_pkg::NUM_SEG-1:0] shift_lat_q;
    logic shifting;

    assign win_len = two_line_q ? clms_pkg::TWO_LINE_LEN :
                                  clms_pkg::ONE_LINE_LEN;
    assign shifting = phase_q < SHIFT_END;

    // Display address for the character now being scanned.
    logic [6:0] base;
    logic [6:0] wrapped;
    logic [6:0] disp_addr;
    logic [7:0] rslot;
    logic [7:0] code;
    logic [4:0] dots;
    logic pix;

    always_comb begin
        base = 7'(char_q) + shift_off_q;
        wrapped = (base >= win_len) ? base - win_len : base;
        disp_addr = (two_line_q && row_q[3]) ?
                    wrapped + clms_pkg::LINE2_BASE : wrapped;
        rslot = char_slot(disp_addr, two_line_q);
        code = char_ram_q[rslot[6:0]];
        if (code[7:4] == 4'h0) begin
            dots = glyph_ram_q[{code[2:0], row_q[2:0]}][4:0];
        end else if ({1'b0, code} < rom_count) begin
            dots = rom_dots(code, row_q[2:0]);
        end else begin
            dots = 5'h00;
        end
        if (row_q == 5'(clms_pkg::NUM_COM - 1)) begin
            pix = icon_ram_q[char_q][3'h4 - col_q];
        end else if (!two_line_q && row_q[3]) begin
            pix = 1'b0;
        end else begin
            pix = dots[3'h4 - col_q];
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            phase_q <= '0;
            char_q <= 4'h0;
            col_q <= 3'h0;
            row_q <= 5'h00;
        end else begin
            phase_q <= (phase_q == PHASE_LAST) ? '0 : phase_q + PW'(1);
            if (phase_q == PHASE_LAST) begin
                char_q <= 4'h0;
                col_q <= 3'h0;
                row_q <= (row_q == 5'(clms_pkg::NUM_COM - 1)) ?
                         5'h00 : row_q + 5'h01;
            end else if (shifting) begin
                if (col_q == 3'(clms_pkg::DOT_COLS - 1)) begin
                    col_q <= 3'h0;
                    char_q <= char_q + 4'h1;
                end else begin
                    col_q <= col_q + 3'h1;
                end
            end
        end
    end

    // Serial fill, then parallel transfer with the matching common.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            shift_lat_q <= '0;
        end else if (shifting) begin
            shift_lat_q <= {shift_lat_q[clms_pkg::NUM_SEG-2:0], pix};
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_seg <= '0;
            o_com <= '0;
        end else if (phase_q == PHASE_LAST) begin
            o_seg <= shift_lat_q;
            o_com <= clms_pkg::NUM_COM'(1) << row_q;
        end
    end

endmodule

`default_nettype wire

// [verif/clms_core_properties.sv]
// Port checker for the character LCD core, bound to every instance.
`timescale 1ns/100ps
`default_nettype none
module clms_core_properties #(
    parameter int COM_CYCLES = clms_pkg::COM_CYCLES
) (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Host write stream.
    input wire logic i_wr_valid,
    input wire clms_pkg::clms_wr_s i_wr,
    input wire logic o_wr_ready,
    // Font-size option pins.
    input wire logic i_font_size_option_a,
    input wire logic i_font_size_option_b,
    // Panel drive.
    input wire logic [clms_pkg::NUM_COM-1:0] o_com,
    input wire logic [clms_pkg::NUM_SEG-1:0] o_seg
);
    localparam int NC = clms_pkg::NUM_COM;
    logic [NC-1:0] com_prev_q;
    int run_q;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    // Counts cycles since the common last moved, to time each period.
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            com_prev_q <= '0;
            run_q <= 0;
        end else begin
            com_prev_q <= o_com;
            run_q <= (o_com != com_prev_q) ? 0 : run_q + 1;
        end
    end
    com_one_hot_a: assert property ($onehot0(o_com))
        else $error("more than one common selected");
    com_period_a: assert property (
        (o_com != com_prev_q && com_prev_q != '0) |-> run_q == COM_CYCLES - 1)
        else $error("common period has the wrong length");
    com_rotate_a: assert property (
        (o_com != com_prev_q && com_prev_q != '0)
        |-> o_com == {com_prev_q[NC-2:0], com_prev_q[NC-1]})
        else $error("commons not scanned in order");
    seg_parallel_a: assert property ($changed(o_seg) |-> $changed(o_com))
        else $error("segments changed without a common change");
    com_stays_a: assert property (o_com != '0 |=> o_com != '0)
        else $error("common select dropped to none");
    seg_idle_a: assert property (o_com == '0 |-> o_seg == '0)
        else $error("segments driven with no common");
    ready_back_a: assert property (!o_wr_ready |=> o_wr_ready)
        else $error("write buffer stayed full");
    ready_fall_a: assert property (
        $past(o_wr_ready) |-> o_wr_ready)
        else $error("write buffer stalled the host");
    row_icon_c: cover property (o_com[NC-1]);
    row_line2_c: cover property (o_com[8] && o_seg != '0);
    seg_load_c: cover property ($changed(o_seg));
endmodule

bind clms_core clms_core_properties #(.COM_CYCLES(COM_CYCLES)) i_props (
    .i_clk(i_clk), .i_rst_b(i_rst_b), .i_wr_valid(i_wr_valid),
    .i_wr(i_wr), .o_wr_ready(o_wr_ready),
    .i_font_size_option_a(i_font_size_option_a),
    .i_font_size_option_b(i_font_size_option_b),
    .o_com(o_com), .o_seg(o_seg));
`default_nettype wire

// [verif/clms_host_model.sv]
// Behavioural host that offers write bytes to the core on its stream.
`timescale 1ns/100ps
`default_nettype none
module clms_host_model (
    // Clock and reset.
    input wire logic i_clk,
    input wire logic i_rst_b,
    // Write stream towards the core.
    input wire logic i_wr_ready,
    output var logic o_wr_valid,
    output var clms_pkg::clms_wr_s o_wr
);
    initial begin
        o_wr_valid = 1'b0;
        o_wr = '0;
    end
    // Write only: the host never reads anything back.
    task automatic send(input logic rs, input logic [7:0] data);
        @(posedge i_clk);
        o_wr_valid <= 1'b1;
        o_wr <= {rs, data};
        do @(posedge i_clk); while (i_wr_ready !== 1'b1 || !i_rst_b);
        o_wr_valid <= 1'b0;
        // Released data is inverted so a stale byte never looks offered.
        o_wr <= ~o_wr;
    endtask
endmodule
`default_nettype wire

// [verif/tb.sv]
// Self-checking bench for the character LCD core.
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int COM_N = 90;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic wr_valid;
    clms_pkg::clms_wr_s wr;
    logic wr_ready;
    logic opt_a = 1'b0;
    logic opt_b = 1'b0;
    logic [clms_pkg::NUM_COM-1:0] com;
    logic [clms_pkg::NUM_SEG-1:0] seg;
    logic [8:0] rom_cnt = clms_pkg::ROM_COUNT_00;
    logic [8:0] cnt_tab [4] = '{clms_pkg::ROM_COUNT_00,
        clms_pkg::ROM_COUNT_01, clms_pkg::ROM_COUNT_10, clms_pkg::ROM_COUNT_11};
    // Only glyph slot 0 is mirrored; the bench uses no other user glyph.
    logic [4:0] gmem [0:7];
    int mismatches = 0;
    int tests_run = 0;
    always #25 clk = ~clk;
    clms_core #(.COM_CYCLES(COM_N)) i_clms_core (
        .i_clk(clk), .i_rst_b(rst_b), .i_wr_valid(wr_valid), .i_wr(wr),
        .o_wr_ready(wr_ready), .i_font_size_option_a(opt_a),
        .i_font_size_option_b(opt_b), .o_com(com), .o_seg(seg));
    clms_host_model i_clms_host_model (
        .i_clk(clk), .i_rst_b(rst_b), .i_wr_ready(wr_ready),
        .o_wr_valid(wr_valid), .o_wr(wr));
    task automatic check(input logic [79:0] seen, input logic [79:0] exp);
        tests_run++;
        if (seen !== exp) begin
            mismatches++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    function automatic logic [4:0] pat(input logic [7:0] c, input int r);
        logic [2:0] row;
        row = 3'(r % 8);
        if (c[7:4] == 4'h0) return gmem[row];
        if ({1'b0, c} >= rom_cnt) return 5'h00;
        return c[4:0] ^ {c[7:6], row};
    endfunction
    task automatic put(input logic rs, input logic [7:0] d);
        i_clms_host_model.send(rs, d);
    endtask
    // Waits for a second fresh selection of row r, so late writes show.
    task automatic grab(input int r, output logic [79:0] s);
        int n;
        int hits;
        logic prev;
        n = 0;
        hits = 0;
        prev = 1'b1;
        while (hits < 2 && n < 4000) begin
            @(posedge clk) #1 n++;
            if (com[r] === 1'b1 && prev !== 1'b1) hits++;
            prev = com[r];
        end
        if (n >= 4000) check(80'h0, 80'h1);
        s = seg;
    endtask
    task automatic t_glyph();
        logic [79:0] s;
        put(0, 8'h40);
        for (int r = 0; r < 8; r++) begin
            gmem[r] = 5'(r * 3 + 1);
            put(1, {3'h7, gmem[r]});
        end
        put(0, 8'h80);
        put(1, 8'h08);
        put(1, 8'h00);
        put(1, 8'h41);
        for (int r = 0; r < 8; r += 7) begin
            grab(r, s);
            check(s[79-:5], pat(8'h08, r));
            check(s[74-:5], pat(8'h00, r));
            check(s[69-:5], pat(8'h41, r));
        end
        grab(8, s);
        check(s, 80'h0);
    endtask
    task automatic t_font();
        logic [79:0] s;
        put(1, 8'hF8);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            {opt_b, opt_a} <= 2'(k);
            rom_cnt = cnt_tab[k];
            grab(0, s);
            check(s[64-:5], pat(8'hF8, 0));
        end
    endtask
    task automatic t_shift1();
        logic [79:0] s;
        put(0, 8'hCF);
        put(1, 8'h55);
        put(0, 8'h1C);
        grab(0, s);
        check(s[79-:5], pat(8'h55, 0));
        check(s[74-:5], pat(8'h08, 0));
        put(0, 8'h18);
        put(0, 8'h18);
        grab(0, s);
        check(s[79-:5], pat(8'h00, 0));
        check(s[69-:5], pat(8'hF8, 0));
    endtask
    task automatic t_two();
        logic [79:0] s;
        put(0, 8'h28);
        put(0, 8'hA7);
        put(1, 8'h47);
        put(1, 8'h5A);
        put(0, 8'hE7);
        put(1, 8'h66);
        grab(8, s);
        check(s[79-:5], pat(8'h5A, 8));
        grab(0, s);
        check(s[79-:5], pat(8'h08, 0));
        put(0, 8'h1C);
        grab(0, s);
        check(s[79-:5], pat(8'h47, 0));
        grab(8, s);
        check(s[79-:5], pat(8'h66, 8));
        check(s[74-:5], pat(8'h5A, 8));
    endtask
    task automatic t_icon();
        logic [79:0] s;
        put(0, 8'h30);
        put(1, 8'h15);
        put(1, 8'h0A);
        grab(16, s);
        check(s[79-:5], 5'h15);
        check(s[74-:5], 5'h0A);
        put(0, 8'h04);
        put(0, 8'h32);
        put(1, 8'h1F);
        put(1, 8'h03);
        grab(16, s);
        check(s[69-:5], 5'h1F);
        check(s[74-:5], 5'h03);
        put(0, 8'h06);
    endtask
    initial begin
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        #1 check({79'h0, wr_ready}, 80'h1);
        t_glyph();
        t_font();
        t_shift1();
        t_two();
        t_icon();
        conclude();
    end
    initial begin
        #(80000 * 50);
        mismatches++;
        $display("[ERR] %0t watchdog expired", $time);
        conclude();
    end
endmodule
`default_nettype wire
